// *** design/serial_rx_pkg.sv ***
// Overview of operation
// - Completed frame moved into data register sets receive full, bit 5.
// - Receive full clears by status read while set, then low data read.
// - Idle flag, bit 4, after 10 ones (short) or 11 ones (long).
// - After idle clears, a valid frame must set receive full before idle again.
// - No idle flag while receiver wakeup is set.
// - Overrun, bit 3, set at mid point of the new frame's stop bit while data unread.
// - On overrun the new frame is dropped; held data stays unchanged.
// - Noise flag, bit 2, set with receive full, never on overrun.
// - Noise and parity flags clear by status read then low data read.
// - Framing flag, bit 1, when stop bit is zero, with receive full.
// - While framing flag is set, further frames are not accepted.
// - Parity flag, bit 0, on parity mismatch when enabled, with receive full.
package serial_rx_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_BAUD = 8'h01;
   localparam logic [7:0] ADDR_STATUS = 8'h02;
   localparam logic [7:0] ADDR_DATA_HIGH = 8'h03;
   localparam logic [7:0] ADDR_DATA_LOW = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h05;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h06;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int FLAG_FULL = 5;
   localparam int FLAG_IDLE = 4;
   localparam int FLAG_OR = 3;
   localparam int FLAG_NOISE = 2;
   localparam int FLAG_FRAME = 1;
   localparam int FLAG_PARITY = 0;
   localparam int CTRL_PAR_EN = 0;
   localparam int CTRL_PAR_ODD = 1;
   localparam int CTRL_LONG = 2;
   localparam int CTRL_WAKE = 3;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [7:0] BAUD_RESET = 8'h1A;
   localparam logic [5:0] FLAGS_RESET = 6'h00;
   // ------------------------------------------------------------
   // Sampling and frame timing
   // ------------------------------------------------------------
   localparam logic [3:0] OS_LAST = 4'hF;
   localparam logic [3:0] SAMPLE_A = 4'h7;
   localparam logic [3:0] SAMPLE_B = 4'h8;
   localparam logic [3:0] SAMPLE_C = 4'h9;
   localparam logic [3:0] LAST_BIT_SHORT = 4'h7;
   localparam logic [3:0] LAST_BIT_LONG = 4'h8;
   localparam logic [3:0] IDLE_ONES_SHORT = 4'hA;
   localparam logic [3:0] IDLE_ONES_LONG = 4'hB;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_START,
      ST_DATA,
      ST_STOP
   } rx_state_t;
endpackage : serial_rx_pkg

// *** design/rx_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface rx_link_if;
   logic line;
   logic os_tick;
   logic [7:0] divisor;
   modport sync_mp (output line);
   modport tick_mp (input divisor, output os_tick);
   modport core_mp (input line, input os_tick, output divisor);
endinterface : rx_link_if
`default_nettype wire

// *** design/rx_line_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module rx_line_sync (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic rxd,
   rx_link_if.sync_mp link
);
   typedef struct packed {
      logic meta;
      logic level;
   } sync_t;

   sync_t r;
   sync_t next_r;

   // ------------------------------------------------------------
   // Two stages; only the second is read
   // ------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.meta = rxd;
      next_r.level = r.meta;
   end

   // Idle line is high, so reset to one
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         r <= '1;
      end else begin
         r <= next_r;
      end
   end

   assign link.line = r.level;
endmodule : rx_line_sync
`default_nettype wire

// *** design/rx_os_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
module rx_os_tick (
   input wire logic clk_sys,
   input wire logic srst,
   rx_link_if.tick_mp link
);
   typedef struct packed {
      logic [7:0] count;
      logic tick;
   } tick_t;

   tick_t r;
   tick_t next_r;

   // ------------------------------------------------------------
   // Oversampling tick, one per divisor plus one clocks
   // ------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.tick = 1'b0;
      if (r.count >= link.divisor) begin
         next_r.count = 8'h00;
         next_r.tick = 1'b1;
      end else begin
         next_r.count = r.count + 8'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign link.os_tick = r.tick;
endmodule : rx_os_tick
`default_nettype wire

// *** design/uart_receive_status_flags.sv ***
`timescale 1ns/1ps
`default_nettype none
module uart_receive_status_flags (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic rxd,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   output logic irq
);
   typedef struct packed {
      logic [3:0] ctrl;
      logic [7:0] baud;
      logic [5:0] flags;
      logic [5:0] armed;
      logic idle_armed;
      logic [8:0] data;
      logic [5:0] irq_stat;
      logic [5:0] irq_mask;
      logic [7:0] rdata;
      serial_rx_pkg::rx_state_t state;
      logic [3:0] os_cnt;
      logic [3:0] bit_cnt;
      logic [8:0] shift;
      logic [1:0] samp;
      logic noise;
      logic parity;
      logic [3:0] idle_cnt;
      logic idle_done;
   } core_t;

   core_t r;
   core_t next_r;

   rx_link_if link ();

   rx_line_sync u_sync (
      .clk_sys(clk_sys),
      .srst(srst),
      .rxd(rxd),
      .link(link.sync_mp)
   );

   rx_os_tick u_tick (
      .clk_sys(clk_sys),
      .srst(srst),
      .link(link.tick_mp)
   );

   assign link.divisor = r.baud;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic vote(input logic a, input logic b, input logic c);
      vote = (a & b) | (a & c) | (b & c);
   endfunction : vote

   function automatic logic disagree(input logic a, input logic b, input logic c);
      disagree = !((a == b) && (b == c));
   endfunction : disagree

   function automatic logic [3:0] bump(input logic [3:0] v);
      bump = v + 4'h1;
   endfunction : bump

   // ------------------------------------------------------------
   // Receiver and flag logic
   // ------------------------------------------------------------
   always_comb begin
      logic bit_val;
      logic bit_noisy;
      logic fr_done;
      logic [8:0] fr_data;
      logic fr_noise;
      logic fr_stop_err;
      logic fr_par_err;
      logic idle_seen;
      logic [3:0] last_bit;
      logic [3:0] idle_target;
      logic [5:0] ev;
      bit_val = 1'b0;
      bit_noisy = 1'b0;
      fr_done = 1'b0;
      fr_data = 9'h000;
      fr_noise = 1'b0;
      fr_stop_err = 1'b0;
      fr_par_err = 1'b0;
      idle_seen = 1'b0;
      ev = 6'h00;
      last_bit = serial_rx_pkg::LAST_BIT_SHORT;
      idle_target = serial_rx_pkg::IDLE_ONES_SHORT;
      next_r = r;
      // Read data is zero outside a read
      next_r.rdata = 8'h00;
      if (r.ctrl[serial_rx_pkg::CTRL_LONG]) begin
         last_bit = serial_rx_pkg::LAST_BIT_LONG;
         idle_target = serial_rx_pkg::IDLE_ONES_LONG;
      end else begin
         last_bit = serial_rx_pkg::LAST_BIT_SHORT;
         idle_target = serial_rx_pkg::IDLE_ONES_SHORT;
      end

      // Three samples around mid bit
      if (link.os_tick) begin
         if (r.os_cnt == serial_rx_pkg::SAMPLE_A) begin
            next_r.samp[0] = link.line;
         end
         if (r.os_cnt == serial_rx_pkg::SAMPLE_B) begin
            next_r.samp[1] = link.line;
         end
         bit_val = vote(r.samp[0], r.samp[1], link.line);
         bit_noisy = disagree(r.samp[0], r.samp[1], link.line);
      end

      case (r.state)
         serial_rx_pkg::ST_IDLE: begin
            if (!link.line) begin
               next_r.state = serial_rx_pkg::ST_START;
               next_r.os_cnt = 4'h0;
               next_r.noise = 1'b0;
               next_r.parity = 1'b0;
               next_r.idle_cnt = 4'h0;
               next_r.idle_done = 1'b0;
            end else if (link.os_tick) begin
               next_r.os_cnt = bump(r.os_cnt);
               // count idle bit times
               // Counted from stop mid point, stop bit excluded
               if (r.os_cnt == serial_rx_pkg::OS_LAST && !r.idle_done) begin
                  next_r.idle_cnt = bump(r.idle_cnt);
                  if (next_r.idle_cnt == idle_target) begin
                     idle_seen = 1'b1;
                     next_r.idle_done = 1'b1;
                  end
               end
            end
         end
         serial_rx_pkg::ST_START: begin
            if (link.os_tick) begin
               next_r.os_cnt = bump(r.os_cnt);
               if (r.os_cnt == serial_rx_pkg::SAMPLE_C) begin
                  next_r.noise = bit_noisy;
                  // False start goes back to idle
                  if (bit_val) begin
                     next_r.state = serial_rx_pkg::ST_IDLE;
                     next_r.os_cnt = 4'h0;
                  end
               end
               if (r.os_cnt == serial_rx_pkg::OS_LAST) begin
                  next_r.state = serial_rx_pkg::ST_DATA;
                  next_r.bit_cnt = 4'h0;
               end
            end
         end
         serial_rx_pkg::ST_DATA: begin
            if (link.os_tick) begin
               next_r.os_cnt = bump(r.os_cnt);
               if (r.os_cnt == serial_rx_pkg::SAMPLE_C) begin
                  next_r.shift = {bit_val, r.shift[8:1]};
                  next_r.parity = r.parity ^ bit_val;
                  // Noise on any bit marks the frame
                  next_r.noise = r.noise | bit_noisy;
               end
               if (r.os_cnt == serial_rx_pkg::OS_LAST) begin
                  next_r.bit_cnt = r.bit_cnt + 4'h1;
                  if (r.bit_cnt == last_bit) begin
                     next_r.state = serial_rx_pkg::ST_STOP;
                  end
               end
            end
         end
         serial_rx_pkg::ST_STOP: begin
            if (link.os_tick) begin
               next_r.os_cnt = bump(r.os_cnt);
               // Ends at mid stop bit to allow for clock skew
               if (r.os_cnt == serial_rx_pkg::SAMPLE_C) begin
                  fr_done = 1'b1;
                  fr_noise = r.noise | bit_noisy;
                  fr_stop_err = !bit_val;
                  // parity against type
                  // Parity bit stays in the data as received
                  fr_par_err = r.ctrl[serial_rx_pkg::CTRL_PAR_EN]
                     & (r.parity != r.ctrl[serial_rx_pkg::CTRL_PAR_ODD]);
                  if (r.ctrl[serial_rx_pkg::CTRL_LONG]) begin
                     fr_data = r.shift;
                  end else begin
                     fr_data = {1'b0, r.shift[8:1]};
                  end
                  next_r.state = serial_rx_pkg::ST_IDLE;
                  next_r.os_cnt = 4'h0;
                  next_r.idle_cnt = 4'h0;
                  next_r.idle_done = 1'b0;
               end
            end
         end
         default: begin
            next_r.state = serial_rx_pkg::ST_IDLE;
         end
      endcase

      // ------------------------------------------------------------
      // Register reads and writes
      // ------------------------------------------------------------
      if (rd_stb) begin
         if (addr == serial_rx_pkg::ADDR_CTRL) begin
            next_r.rdata = {4'h0, r.ctrl};
         end else if (addr == serial_rx_pkg::ADDR_BAUD) begin
            next_r.rdata = r.baud;
         end else if (addr == serial_rx_pkg::ADDR_STATUS) begin
            next_r.rdata = {2'b00, r.flags};
            // arm clear of flags seen set
            // Each status read replaces the record
            next_r.armed = r.flags;
         end else if (addr == serial_rx_pkg::ADDR_DATA_HIGH) begin
            next_r.rdata = {7'h00, r.data[8]};
         end else if (addr == serial_rx_pkg::ADDR_DATA_LOW) begin
            next_r.rdata = r.data[7:0];
            next_r.flags = r.flags & ~r.armed;
            next_r.armed = 6'h00;
         end else if (addr == serial_rx_pkg::ADDR_IRQ_STAT) begin
            next_r.rdata = {2'b00, r.irq_stat};
         end else if (addr == serial_rx_pkg::ADDR_IRQ_MASK) begin
            next_r.rdata = {2'b00, r.irq_mask};
         end else begin
            next_r.rdata = 8'h00;
         end
      end

      // Status and data writes are ignored
      if (wr_stb) begin
         if (addr == serial_rx_pkg::ADDR_CTRL) begin
            next_r.ctrl = wdata[3:0];
         end else if (addr == serial_rx_pkg::ADDR_BAUD) begin
            next_r.baud = wdata;
         end else if (addr == serial_rx_pkg::ADDR_IRQ_STAT) begin
            next_r.irq_stat = r.irq_stat & ~wdata[5:0];
         end else if (addr == serial_rx_pkg::ADDR_IRQ_MASK) begin
            next_r.irq_mask = wdata[5:0];
         end
      end

      // ------------------------------------------------------------
      // Flag setting; a set always beats a clear
      // ------------------------------------------------------------
      // wakeup suppresses idle
      if (idle_seen && r.idle_armed && !r.ctrl[serial_rx_pkg::CTRL_WAKE]) begin
         ev[serial_rx_pkg::FLAG_IDLE] = 1'b1;
         next_r.idle_armed = 1'b0;
      end

      if (fr_done && !r.flags[serial_rx_pkg::FLAG_FRAME]) begin
         // A frame racing a data read still overruns
         if (r.flags[serial_rx_pkg::FLAG_FULL]) begin
            ev[serial_rx_pkg::FLAG_OR] = 1'b1;
         end else begin
            next_r.data = fr_data;
            ev[serial_rx_pkg::FLAG_FULL] = 1'b1;
            ev[serial_rx_pkg::FLAG_NOISE] = fr_noise;
            // Framing error frames still load the data
            ev[serial_rx_pkg::FLAG_FRAME] = fr_stop_err;
            ev[serial_rx_pkg::FLAG_PARITY] = fr_par_err;
            next_r.idle_armed = 1'b1;
         end
      end

      next_r.flags = next_r.flags | ev;
      next_r.irq_stat = next_r.irq_stat | ev;
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         r <= '0;
         r.ctrl <= serial_rx_pkg::CTRL_RESET;
         r.baud <= serial_rx_pkg::BAUD_RESET;
         r.flags <= serial_rx_pkg::FLAGS_RESET;
         r.state <= serial_rx_pkg::ST_IDLE;
      end else begin
         r <= next_r;
      end
   end

   assign rdata = r.rdata;
   // Level interrupt, no edge so nothing is missed
   assign irq = |(r.irq_stat & r.irq_mask);
endmodule : uart_receive_status_flags
`default_nettype wire

// *** bench/serial_rx_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_rx_monitor (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic rxd,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] rdata,
   input wire logic irq
);
   logic [7:0] age;
   logic seen_full;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // No frame can finish within 100 cycles of reset
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         age <= 8'h00;
         seen_full <= 1'b0;
      end else begin
         age <= (age == 8'hFF) ? age : age + 8'h01;
         seen_full <= seen_full | ($past(rd_stb) && $past(addr) == serial_rx_pkg::ADDR_STATUS && rdata[5]);
      end
   end
   sequence s_stat;
      rd_stb && addr == serial_rx_pkg::ADDR_STATUS;
   endsequence
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   a_rdata_rest_zero: assert property (!rd_stb |=> rdata == 8'h00) else $error("rdata not zero");
   a_status_reset_zero: assert property (s_stat and age < 8'h64 |=> rdata == 8'h00) else $error("flags after reset");
   a_irq_reset_low: assert property (age < 8'h64 |-> !irq) else $error("irq after reset");
   a_status_top_zero: assert property (s_stat |=> rdata[7:6] == 2'b00) else $error("status top bits");
   a_unmapped_zero: assert property (rd_stb && addr > serial_rx_pkg::ADDR_IRQ_MASK |=> rdata == 8'h00)
      else $error("unmapped read");
   a_flags_held_reads: assert property (s_stat ##1 s_stat |=> ($past(rdata) & ~rdata & 8'h3F) == 8'h00)
      else $error("flag dropped");
   a_error_with_full: assert property (s_stat |=> (rdata[2:0] != 3'b000) -> rdata[5])
      else $error("error flag alone");
   a_idle_needs_frame: assert property (s_stat |=> rdata[4] -> (seen_full || rdata[5]))
      else $error("idle before frame");
endmodule : serial_rx_monitor
bind uart_receive_status_flags serial_rx_monitor i_mon (.clk_sys(clk_sys), .srst(srst), .rxd(rxd), .addr(addr),
   .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq));
`default_nettype wire

// *** bench/serial_tx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model (
   input wire logic clk_sys,
   output logic rxd
);
   // Line idles high between frames
   initial rxd = 1'b1;
   // One bit each 16 clocks; one idle bit after stop so a zero stop is not a start
   task automatic send(input logic [8:0] d, input int n, input logic stp, input logic nz);
      logic b;
      for (int i = 0; i <= n + 2; i++) begin
         b = (i == 0) ? 1'b0 : (i <= n) ? d[i-1] : (i == n + 1) ? stp : 1'b1;
         for (int c = 0; c < 16; c++) begin
            @(posedge clk_sys);
            rxd <= (nz && i == 1 && c == 9) ? ~b : b;
         end
      end
   endtask : send
endmodule : serial_tx_model
`default_nettype wire

// *** bench/uart_receive_status_flags_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module uart_receive_status_flags_bench;
   localparam logic [7:0] A_CT = serial_rx_pkg::ADDR_CTRL;
   localparam logic [7:0] A_ST = serial_rx_pkg::ADDR_STATUS;
   localparam logic [7:0] A_DL = serial_rx_pkg::ADDR_DATA_LOW;
   localparam logic [7:0] A_IS = serial_rx_pkg::ADDR_IRQ_STAT;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic rxd;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [7:0] rdata;
   logic irq;
   int fail_count = 0;
   int checked = 0;
   uart_receive_status_flags i_dut (.clk_sys(clk_sys), .srst(srst), .rxd(rxd), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq));
   serial_tx_model i_tx (.clk_sys(clk_sys), .rxd(rxd));
   initial forever #5 clk_sys = ~clk_sys;
   // ------------------------------------------------------------
   // Bus and compare
   // ------------------------------------------------------------
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wt
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
   endtask : wr
   // Strobe held n cycles gives n back to back reads; the last one's data is kept
   task automatic rd(input logic [7:0] a, input int n, output logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      wt(n);
      rd_stb <= 1'b0;
      #1 d = rdata;
   endtask : rd
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, 1, d);
      chk(d, e);
   endtask : rchk
   // Lets idle set, then clears the status flags
   task automatic drain();
      logic [7:0] d;
      wt(200);
      rd(A_ST, 1, d);
      rd(A_DL, 1, d);
   endtask : drain
   task automatic final_report();
      $display("checks %0d fails %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      rchk(A_ST, 8'h00);
      rchk(A_CT, 8'h00);
      rchk(serial_rx_pkg::ADDR_BAUD, 8'h1A);
      rchk(A_IS, 8'h00);
      rchk(8'h07, 8'h00);
      wr(serial_rx_pkg::ADDR_BAUD, 8'h00);
      wr(serial_rx_pkg::ADDR_IRQ_MASK, 8'h20);
   endtask : t_reset
   task automatic t_basic();
      logic [7:0] d;
      i_tx.send(9'h0A5, 8, 1'b1, 1'b0);
      wt(4);
      chk({7'h00, irq}, 8'h01);
      rd(A_ST, 2, d);
      chk(d, 8'h20);
      @(posedge clk_sys);
      #1 chk(rdata, 8'h00);
      rchk(A_DL, 8'hA5);
      rchk(A_ST, 8'h00);
      wt(100);
      rchk(A_ST, 8'h00);
      wt(40);
      rchk(A_ST, 8'h10);
      rchk(A_DL, 8'hA5);
      wt(200);
      rchk(A_ST, 8'h00);
      rchk(A_IS, 8'h30);
      wr(A_IS, 8'h20);
      wt(1);
      chk({7'h00, irq}, 8'h00);
   endtask : t_basic
   task automatic t_wake();
      wr(A_CT, 8'h08);
      i_tx.send(9'h03C, 8, 1'b1, 1'b0);
      wt(200);
      rchk(A_ST, 8'h20);
      rchk(A_DL, 8'h3C);
      wr(A_CT, 8'h00);
      drain();
   endtask : t_wake
   task automatic t_over();
      i_tx.send(9'h011, 8, 1'b1, 1'b0);
      i_tx.send(9'h022, 8, 1'b1, 1'b0);
      rchk(A_ST, 8'h28);
      rchk(A_DL, 8'h11);
      rchk(A_ST, 8'h00);
      drain();
      i_tx.send(9'h033, 8, 1'b1, 1'b0);
      rchk(A_ST, 8'h20);
      i_tx.send(9'h044, 8, 1'b1, 1'b0);
      rchk(A_DL, 8'h33);
      rchk(A_ST, 8'h08);
      rchk(A_DL, 8'h33);
      rchk(A_ST, 8'h00);
      drain();
   endtask : t_over
   task automatic t_err();
      i_tx.send(9'h05A, 8, 1'b1, 1'b1);
      rchk(A_ST, 8'h24);
      rchk(A_DL, 8'h5A);
      rchk(A_ST, 8'h00);
      drain();
      i_tx.send(9'h066, 8, 1'b0, 1'b0);
      rchk(A_ST, 8'h22);
      i_tx.send(9'h077, 8, 1'b1, 1'b0);
      rchk(A_ST, 8'h22);
      rchk(A_DL, 8'h66);
      rchk(A_ST, 8'h00);
      drain();
   endtask : t_err
   task automatic t_parity();
      logic [7:0] ct [4] = '{8'h01, 8'h01, 8'h03, 8'h02};
      logic [7:0] dt [4] = '{8'h01, 8'h03, 8'h03, 8'h01};
      logic [7:0] ex [4] = '{8'h21, 8'h20, 8'h21, 8'h20};
      for (int i = 0; i < 4; i++) begin
         wr(A_CT, ct[i]);
         i_tx.send({1'b0, dt[i]}, 8, 1'b1, 1'b0);
         rchk(A_ST, ex[i]);
         rchk(A_DL, dt[i]);
         rchk(A_ST, 8'h00);
         drain();
      end
   endtask : t_parity
   task automatic t_long();
      wr(A_CT, 8'h04);
      i_tx.send(9'h1AB, 9, 1'b1, 1'b0);
      rchk(A_ST, 8'h20);
      rchk(serial_rx_pkg::ADDR_DATA_HIGH, 8'h01);
      rchk(A_DL, 8'hAB);
      wt(140);
      rchk(A_ST, 8'h00);
      wt(40);
      rchk(A_ST, 8'h10);
      i_tx.send(9'h0C3, 9, 1'b1, 1'b0);
      srst <= 1'b1;
      wt(3);
      srst <= 1'b0;
      rchk(A_ST, 8'h00);
   endtask : t_long
   initial begin
      wt(10);
      srst <= 1'b0;
      t_reset();
      t_basic();
      t_wake();
      t_over();
      t_err();
      t_parity();
      t_long();
      final_report();
   end
   initial begin
      wt(20000);
      fail_count++;
      final_report();
   end
endmodule : uart_receive_status_flags_bench
`default_nettype wire
